// ### common/adc_logger_map.svh
`ifndef ADC_LOGGER_MAP_SVH
`define ADC_LOGGER_MAP_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CLK_MHZ              125
`define SPI_HALF_NS          500
`define SPI_HALF_CYCLES      ((`SPI_HALF_NS * `CLK_MHZ + 999) / 1000)
`define SAMPLE_PERIOD_MS     100
`define SAMPLE_PERIOD_CYCLES (`SAMPLE_PERIOD_MS * `CLK_MHZ * 1000)

// ----------------------------------------------------------------
// Shared bus select codes
// ----------------------------------------------------------------
`define SELECT_NONE               3'h0
`define CONVERTER_SELECT_CODE     3'h4
`define FIRST_MEMORY_SELECT_CODE  3'h5

// ----------------------------------------------------------------
// Converter frame
// ----------------------------------------------------------------
`define CONV_BITS        6'h11
`define CONV_START_BIT   14
`define CONV_SINGLE_BIT  13
`define CONV_CHAN_BIT    12
`define CONV_MSBF_BIT    11
`define SAMPLE_MASK      12'hFFF

// ----------------------------------------------------------------
// Memory frame
// ----------------------------------------------------------------
`define MEM_BITS         6'h20
`define MEM_WRITE_CMD    8'h02
`define MEM_READ_CMD     8'h03
`define MEM_DUMMY        8'h00
`define RECORD_COUNT     15'h07D0
`define NIBBLE_PAD       4'h0

`endif

// ### common/adc_logger_pkg.sv
package adc_logger_pkg;

    typedef enum logic [3:0] {
        S_IDLE,
        S_INIT_A,
        S_INIT_B,
        S_INIT_C,
        S_SELECT,
        S_SHIFT_LO,
        S_SHIFT_HI,
        S_DESEL,
        S_PUSH,
        S_WAIT
    } state_t;

    typedef enum logic [2:0] {
        STEP_CONV,
        STEP_WR0,
        STEP_WR1,
        STEP_RD0,
        STEP_RD1
    } step_t;

    typedef enum logic [1:0] {
        JOB_READ,
        JOB_RECORD,
        JOB_PLAY
    } job_t;

    typedef logic [12:0] sample_word_t;

    typedef struct packed {
        state_t       state;
        step_t        step;
        job_t         job;
        logic [2:0]   select;
        logic         sclk;
        logic         mosi;
        logic [31:0]  tx;
        logic [31:0]  rx;
        logic [5:0]   bits;
        logic [6:0]   div;
        logic         chan;
        logic [14:0]  index;
        logic [23:0]  wait_cnt;
        logic [11:0]  sample;
        logic         strobe;
        logic         init_done;
        logic         rec_done;
        logic         play_done;
        logic         push;
        logic         busy;
    } ctl_t;

    typedef struct packed {
        logic         head_valid;
        sample_word_t head;
        logic         tail_valid;
        sample_word_t tail;
    } pair_t;

endpackage : adc_logger_pkg

// ### hw/stream_pair_buffer.sv
`timescale 1ns/100ps
`include "adc_logger_map.svh"

module stream_pair_buffer
(
    input  wire logic                         clk,
    input  wire logic                         reset,
    input  wire logic                         in_valid,
    output logic                              in_ready,
    input  wire adc_logger_pkg::sample_word_t in_data,
    output logic                              out_valid,
    input  wire logic                         out_ready,
    output adc_logger_pkg::sample_word_t      out_data
);
    import adc_logger_pkg::*;

    pair_t r;
    pair_t next_r;

    // ------------------------------------------------------------
    // Two entries: head drives the output, tail absorbs a stall
    // ------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        if (r.head_valid && out_ready)
        begin
            if (r.tail_valid)
            begin
                next_r.head       = r.tail;
                next_r.tail_valid = 1'b0;
            end
            else
            begin
                next_r.head_valid = 1'b0;
            end
        end
        if (in_valid && !r.tail_valid)
        begin
            if (!next_r.head_valid)
            begin
                next_r.head       = in_data;
                next_r.head_valid = 1'b1;
            end
            else
            begin
                next_r.tail       = in_data;
                next_r.tail_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            r <= '0;
        else
            r <= next_r;
    end

    assign in_ready  = !r.tail_valid;
    assign out_valid = r.head_valid;
    assign out_data  = r.head;

endmodule : stream_pair_buffer

// ### hw/spi_adc_sample_logger.sv
`timescale 1ns/100ps
`include "adc_logger_map.svh"

// Notes on behaviour
// - Select code 4, then back to zero
// - One selected transaction per conversion
// - Seventeen clocks per conversion read
// - Zeros, start, single, channel, msb-first, zeros
// - Init: deselect, select, deselect, no clocks
// - No transaction before init completes
// - Record channel 0, then replay at rate
// - Record run captures 2000 samples
// - Low byte bank 0, nibble bank 1
// - Upper bank 1 nibble unused, ignored
// - Index spans 32768 entries per bank
// - Write: select, command 02, address, data
module spi_adc_sample_logger
#(
    parameter int unsigned SAMPLE_PERIOD = `SAMPLE_PERIOD_CYCLES
)
(
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic                    init_req,
    input  wire logic                    read_req,
    input  wire logic                    read_channel,
    input  wire logic                    record_req,
    input  wire logic                    play_req,
    output logic                         init_done,
    output logic                         busy,
    output logic                         result_strobe,
    output logic [11:0]                  result_sample,
    output logic                         result_channel,
    output logic                         record_done,
    output logic                         play_done,
    output logic                         sample_valid,
    input  wire logic                    sample_ready,
    output adc_logger_pkg::sample_word_t sample_data,
    output logic [2:0]                   spi_select,
    output logic                         spi_clk,
    output logic                         spi_mosi,
    input  wire logic                    spi_miso
);
    import adc_logger_pkg::*;

    ctl_t r;
    ctl_t next_r;
    logic push_ready;
    logic tick;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] align(input logic [5:0] len, input logic [31:0] word);
        align = word << (6'h20 - len);
    endfunction : align

    function automatic logic [31:0] mem_word(input logic [7:0] cmd, input logic [14:0] idx,
                                             input logic [7:0] data);
        mem_word = {cmd, 1'b0, idx, data};
    endfunction : mem_word

    function automatic ctl_t launch(input ctl_t c, input step_t s);
        ctl_t o;
        o       = c;
        o.step  = s;
        o.state = S_SELECT;
        o.div   = 7'h00;
        o.rx    = '0;
        unique case (s)
            STEP_CONV:
            begin
                o.select = `CONVERTER_SELECT_CODE;
                o.bits   = `CONV_BITS;
                o.tx     = '0;
                o.tx[`CONV_START_BIT]  = 1'b1;
                o.tx[`CONV_SINGLE_BIT] = 1'b1;
                o.tx[`CONV_CHAN_BIT]   = c.chan;
                o.tx[`CONV_MSBF_BIT]   = 1'b1;
                o.tx     = align(`CONV_BITS, o.tx);
            end
            STEP_WR0:
            begin
                o.select = `FIRST_MEMORY_SELECT_CODE;
                o.bits   = `MEM_BITS;
                o.tx     = align(`MEM_BITS, mem_word(`MEM_WRITE_CMD, c.index, c.sample[7:0]));
            end
            STEP_WR1:
            begin
                o.select = `FIRST_MEMORY_SELECT_CODE + 3'h1;
                o.bits   = `MEM_BITS;
                o.tx     = align(`MEM_BITS, mem_word(`MEM_WRITE_CMD, c.index,
                                                     {`NIBBLE_PAD, c.sample[11:8]}));
            end
            STEP_RD0:
            begin
                o.select = `FIRST_MEMORY_SELECT_CODE;
                o.bits   = `MEM_BITS;
                o.tx     = align(`MEM_BITS, mem_word(`MEM_READ_CMD, c.index, `MEM_DUMMY));
            end
            STEP_RD1:
            begin
                o.select = `FIRST_MEMORY_SELECT_CODE + 3'h1;
                o.bits   = `MEM_BITS;
                o.tx     = align(`MEM_BITS, mem_word(`MEM_READ_CMD, c.index, `MEM_DUMMY));
            end
        endcase
        return o;
    endfunction : launch

    assign tick = (r.div == 7'(`SPI_HALF_CYCLES - 1));

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        next_r           = r;
        next_r.strobe    = 1'b0;
        next_r.rec_done  = 1'b0;
        next_r.play_done = 1'b0;
        next_r.div       = tick ? 7'h00 : r.div + 7'h01;
        unique case (r.state)
            S_IDLE:
            begin
                next_r.div = 7'h00;
                if (init_req)
                begin
                    next_r.select = `SELECT_NONE;
                    next_r.state  = S_INIT_A;
                end
                else if (r.init_done && read_req)
                begin
                    next_r.job  = JOB_READ;
                    next_r.chan = read_channel;
                    next_r      = launch(next_r, STEP_CONV);
                end
                else if (r.init_done && record_req)
                begin
                    next_r.job   = JOB_RECORD;
                    next_r.chan  = 1'b0;
                    next_r.index = '0;
                    next_r       = launch(next_r, STEP_CONV);
                end
                else if (r.init_done && play_req)
                begin
                    next_r.job   = JOB_PLAY;
                    next_r.chan  = 1'b0;
                    next_r.index = '0;
                    next_r       = launch(next_r, STEP_RD0);
                end
            end
            S_INIT_A:
            begin
                if (tick)
                begin
                    next_r.select = `CONVERTER_SELECT_CODE;
                    next_r.state  = S_INIT_B;
                end
            end
            S_INIT_B:
            begin
                if (tick)
                begin
                    next_r.select = `SELECT_NONE;
                    next_r.state  = S_INIT_C;
                end
            end
            S_INIT_C:
            begin
                if (tick)
                begin
                    next_r.init_done = 1'b1;
                    next_r.state     = S_IDLE;
                end
            end
            S_SELECT:
            begin
                if (tick)
                begin
                    next_r.mosi  = r.tx[31];
                    next_r.state = S_SHIFT_LO;
                end
            end
            S_SHIFT_LO:
            begin
                if (tick)
                begin
                    next_r.sclk  = 1'b1;
                    next_r.rx    = {r.rx[30:0], spi_miso};
                    next_r.state = S_SHIFT_HI;
                end
            end
            S_SHIFT_HI:
            begin
                if (tick)
                begin
                    next_r.sclk = 1'b0;
                    next_r.tx   = {r.tx[30:0], 1'b0};
                    next_r.mosi = r.tx[30];
                    next_r.bits = r.bits - 6'h01;
                    if (r.bits == 6'h01)
                    begin
                        next_r.mosi   = 1'b0;
                        next_r.select = `SELECT_NONE;
                        next_r.state  = S_DESEL;
                    end
                    else
                    begin
                        next_r.state = S_SHIFT_LO;
                    end
                end
            end
            S_DESEL:
            begin
                if (tick)
                begin
                    unique case (r.step)
                        STEP_CONV:
                        begin
                            next_r.sample = r.rx[11:0] & `SAMPLE_MASK;
                            next_r.strobe = 1'b1;
                            if (r.job == JOB_RECORD)
                                next_r = launch(next_r, STEP_WR0);
                            else
                            begin
                                next_r.push  = 1'b1;
                                next_r.state = S_PUSH;
                            end
                        end
                        STEP_WR0:
                            next_r = launch(next_r, STEP_WR1);
                        STEP_WR1:
                        begin
                            next_r.index = r.index + 15'h0001;
                            if (r.index + 15'h0001 == `RECORD_COUNT)
                            begin
                                next_r.rec_done = 1'b1;
                                next_r.state    = S_IDLE;
                            end
                            else
                            begin
                                next_r.wait_cnt = 24'(SAMPLE_PERIOD - 1);
                                next_r.state    = S_WAIT;
                            end
                        end
                        STEP_RD0:
                        begin
                            next_r.sample[7:0] = r.rx[7:0];
                            next_r = launch(next_r, STEP_RD1);
                        end
                        STEP_RD1:
                        begin
                            next_r.sample[11:8] = r.rx[3:0];
                            next_r.strobe       = 1'b1;
                            next_r.push         = 1'b1;
                            next_r.state        = S_PUSH;
                        end
                    endcase
                end
            end
            S_PUSH:
            begin
                if (push_ready)
                begin
                    next_r.push = 1'b0;
                    if (r.job == JOB_READ)
                        next_r.state = S_IDLE;
                    else
                    begin
                        next_r.index = r.index + 15'h0001;
                        if (r.index + 15'h0001 == `RECORD_COUNT)
                        begin
                            next_r.play_done = 1'b1;
                            next_r.state     = S_IDLE;
                        end
                        else
                        begin
                            next_r.wait_cnt = 24'(SAMPLE_PERIOD - 1);
                            next_r.state    = S_WAIT;
                        end
                    end
                end
            end
            S_WAIT:
            begin
                next_r.wait_cnt = r.wait_cnt - 24'h000001;
                if (r.wait_cnt == 24'h000000)
                begin
                    if (r.job == JOB_RECORD)
                        next_r = launch(next_r, STEP_CONV);
                    else
                        next_r = launch(next_r, STEP_RD0);
                end
            end
        endcase
        next_r.busy = (next_r.state != S_IDLE);
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            r       <= '0;
            r.state <= S_IDLE;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Output stream buffer
    // ------------------------------------------------------------
    stream_pair_buffer u_buffer
    (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (r.push),
        .in_ready  (push_ready),
        .in_data   ({r.chan, r.sample}),
        .out_valid (sample_valid),
        .out_ready (sample_ready),
        .out_data  (sample_data)
    );

    assign init_done      = r.init_done;
    assign busy           = r.busy;
    assign result_strobe  = r.strobe;
    assign result_sample  = r.sample;
    assign result_channel = r.chan;
    assign record_done    = r.rec_done;
    assign play_done      = r.play_done;
    assign spi_select     = r.select;
    assign spi_clk        = r.sclk;
    assign spi_mosi       = r.mosi;

endmodule : spi_adc_sample_logger

// ### verif/adc_logger_monitor.sv
`timescale 1ns/100ps

module adc_logger_monitor
(
    input wire logic                         clk,
    input wire logic                         reset,
    input wire logic                         init_req,
    input wire logic                         read_req,
    input wire logic                         init_done,
    input wire logic                         busy,
    input wire logic                         result_strobe,
    input wire logic                         record_done,
    input wire logic                         play_done,
    input wire logic                         sample_valid,
    input wire logic                         sample_ready,
    input wire adc_logger_pkg::sample_word_t sample_data,
    input wire logic [2:0]                   spi_select,
    input wire logic                         spi_clk,
    input wire logic                         spi_mosi
);
    import adc_logger_pkg::*;

    logic [2:0] sel_q;
    logic       sclk_q;
    logic [5:0] rises;

    // ----------------------------------------
    // Serial clock rises per selected frame
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sel_q  <= 3'h0;
            sclk_q <= 1'b0;
            rises  <= 6'h00;
        end
        else
        begin
            sel_q  <= spi_select;
            sclk_q <= spi_clk;
            rises  <= (spi_select != sel_q) ? 6'h00 : rises + {5'h00, spi_clk & ~sclk_q};
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_init_take;
        init_req && !busy;
    endsequence
    sequence s_init_end;
        ##1 busy ##[1:250] (init_done && !busy);
    endsequence

    a_select_legal: assert property (spi_select inside {3'h0, 3'h4, 3'h5, 3'h6})
        else $error("select code outside the used set");
    a_clk_selected: assert property (spi_clk |-> spi_select != 3'h0)
        else $error("serial clock with nothing selected");
    a_conv_len: assert property (spi_select == 3'h0 && sel_q == 3'h4
        |-> rises == 6'h00 || rises == 6'h11) else $error("converter frame length wrong");
    a_mem_len: assert property (spi_select == 3'h0 && sel_q inside {3'h5, 3'h6}
        |-> rises == 6'h20) else $error("memory frame length wrong");
    a_init_quiet: assert property (!init_done |-> !spi_clk)
        else $error("serial clock before init finished");
    a_init_walk: assert property (s_init_take |-> s_init_end)
        else $error("init sequence did not finish in time");
    a_early_refuse: assert property (!busy && !init_done && !init_req |=> !busy)
        else $error("request taken before init");
    a_read_taken: assert property (!busy && init_done && read_req && !init_req |=> busy)
        else $error("read request not taken in idle");
    a_strobe_pulse: assert property (result_strobe |=> !result_strobe)
        else $error("result strobe longer than one cycle");
    a_done_pulse: assert property (record_done || play_done |=> !record_done && !play_done)
        else $error("done strobe longer than one cycle");
    a_mosi_steady: assert property (spi_clk && sclk_q |-> $stable(spi_mosi))
        else $error("host data moved while serial clock high");
    a_stream_hold: assert property (sample_valid && !sample_ready
        |=> sample_valid && $stable(sample_data)) else $error("stalled word dropped or changed");
endmodule : adc_logger_monitor

// ### verif/adc_sram_model.sv
`timescale 1ns/100ps

module adc_sram_model
(
    input  wire logic       clk,
    input  wire logic [2:0] spi_select,
    input  wire logic       spi_clk,
    input  wire logic       spi_mosi,
    output logic            spi_miso
);
    logic [11:0] code;
    logic [16:0] cmd;
    logic [31:0] rx;
    logic [14:0] addr;
    logic [5:0]  cnt;
    int          n_wr;
    logic [7:0]  mem0 [0:32767];
    logic [7:0]  mem1 [0:32767];

    // ----------------------------------------
    // Device answer bit at position n
    // ----------------------------------------
    function automatic logic out_bit(input logic [5:0] n);
        logic [7:0] b;
        b = spi_select[1] ? mem1[addr] : mem0[addr];
        if (spi_select == 3'h4)
            return (n < 6'h05) ? 1'b1 : code[6'h10 - n];
        if (n >= 6'h18 && n < 6'h20)
            return b[6'h1F - n];
        return ~spi_miso;
    endfunction : out_bit

    initial
    begin
        spi_miso = 1'b0;
        n_wr = 0;
        cnt = 6'h00;
    end

    // ----------------------------------------
    // Shift logic, restarted by each select
    // ----------------------------------------
    always @(spi_select)
    begin
        cnt = 6'h00;
        spi_miso = out_bit(6'h00);
    end

    always @(posedge spi_clk)
    begin
        rx = {rx[30:0], spi_mosi};
        cnt = cnt + 6'h01;
        if (cnt == 6'h18)
            addr = rx[14:0];
        if (spi_select == 3'h4 && cnt == 6'h11)
            cmd = rx[16:0];
        if (spi_select != 3'h4 && cnt == 6'h20 && rx[31:24] == 8'h02)
        begin
            n_wr++;
            if (spi_select[1])
                mem1[rx[22:8]] = rx[7:0];
            else
                mem0[rx[22:8]] = rx[7:0];
        end
    end

    always @(negedge spi_clk)
        spi_miso = out_bit(cnt);

    // Released line wanders while nothing is selected
    always @(posedge clk)
        if (spi_select == 3'h0)
            spi_miso <= ~spi_miso;
endmodule : adc_sram_model

// ### verif/tb.sv
`timescale 1ns/100ps

module tb;
    import adc_logger_pkg::*;

    logic clk, reset, init_req, read_req, read_channel, record_req, play_req;
    logic sample_ready, init_done, busy, result_strobe, result_channel;
    logic record_done, play_done, sample_valid, spi_clk, spi_mosi, spi_miso;
    logic [11:0]  result_sample;
    logic [2:0]   spi_select;
    sample_word_t sample_data;
    sample_word_t got[$];
    sample_word_t res[$];
    int           n_mismatch;
    int           n_checks;

    spi_adc_sample_logger #(.SAMPLE_PERIOD(20)) dut (.clk, .reset, .init_req, .read_req,
        .read_channel, .record_req, .play_req, .init_done, .busy, .result_strobe,
        .result_sample, .result_channel, .record_done, .play_done, .sample_valid,
        .sample_ready, .sample_data, .spi_select, .spi_clk, .spi_mosi, .spi_miso);
    adc_sram_model mdl (.clk, .spi_select, .spi_clk, .spi_mosi, .spi_miso);

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (sample_valid && sample_ready)
            got.push_back(sample_data);
        if (result_strobe)
            res.push_back({result_channel, result_sample});
    end

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic request(input logic [3:0] which, input logic ch);
        {init_req, read_req, record_req, play_req} = which;
        read_channel = ch;
        tick(1);
        {init_req, read_req, record_req, play_req} = 4'h0;
    endtask : request

    task automatic wait_idle();
        int i;
        for (i = 0; i < 20000 && busy !== 1'b0; i++)
            tick(1);
        check(busy, 1'b0);
        tick(3);
    endtask : wait_idle

    task automatic wait_count(input logic use_wr, input int n);
        int i;
        for (i = 0; i < 30000 && (use_wr ? mdl.n_wr : res.size()) < n; i++)
            tick(1);
        check(i < 30000, 1'b1);
    endtask : wait_count

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    initial
    begin
        #800_000;
        n_mismatch++;
        summarize();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        {reset, init_req, read_req, read_channel, record_req, play_req} = 6'h20;
        sample_ready = 1'b1;
        n_mismatch = 0;
        n_checks = 0;
        tick(6);
        reset = 1'b0;
        check({spi_select, busy, init_done, sample_valid}, 6'h00);
        request(4'h4, 1'b0);
        tick(5);
        check({spi_select, busy}, 4'h0);
        request(4'h8, 1'b0);
        wait_idle();
        check({init_done, res.size() == 0}, 2'h3);
        for (int c = 0; c < 2; c++)
        begin
            mdl.code = c ? 12'hFFF : 12'h000;
            request(4'h4, c[0]);
            tick(100);
            request(4'h4, ~c[0]);
            wait_idle();
            check(mdl.cmd, {4'h3, c[0], 12'h800});
            check(res.pop_front(), {c[0], mdl.code});
            check(res.size(), 0);
            check(got.pop_front(), {c[0], mdl.code});
        end
        sample_ready = 1'b0;
        for (int i = 1; i < 4; i++)
        begin
            wait_idle();
            mdl.code = 12'(i);
            request(4'h4, 1'b0);
            wait_count(1'b0, i);
        end
        tick(10);
        check({busy, sample_valid}, 2'h3);
        sample_ready = 1'b1;
        wait_idle();
        for (int i = 1; i < 4; i++)
            check(got.pop_front(), i);
        mdl.code = 12'h9C3;
        request(4'h2, 1'b0);
        wait_count(1'b1, 2);
        mdl.code = 12'h5A7;
        wait_count(1'b1, 4);
        check(mdl.cmd, {4'h3, 1'b0, 12'h800});
        check({mdl.mem1[0], mdl.mem0[0]}, 16'h09C3);
        check({mdl.mem1[1], mdl.mem0[1]}, 16'h05A7);
        check({busy, record_done, play_done}, 3'h4);
        reset = 1'b1;
        tick(6);
        reset = 1'b0;
        check({busy, init_done, spi_select}, 5'h00);
        request(4'h8, 1'b0);
        wait_idle();
        got.delete();
        res.delete();
        {mdl.mem1[0], mdl.mem0[0], mdl.mem1[1], mdl.mem0[1]} = 32'hF2340FFF;
        request(4'h1, 1'b0);
        wait_count(1'b0, 2);
        tick(5);
        check(res[0], 13'h0234);
        check(res[1], 13'h0FFF);
        check(got[0], 13'h0234);
        check(got[1], 13'h0FFF);
        summarize();
    end
endmodule : tb

bind spi_adc_sample_logger adc_logger_monitor mon (.clk, .reset, .init_req, .read_req,
    .init_done, .busy, .result_strobe, .record_done, .play_done, .sample_valid,
    .sample_ready, .sample_data, .spi_select, .spi_clk, .spi_mosi);
